// [rts_tx_clock_ctrl.sv]
// reset sequencing and transmit symbol clock selection for a four-pair phy
// assumes requests and role come from logic on clk_in; recovered clock is a pin
//
// What this block does
// - coding reset on power-on or management request
// - symbol tick locked to transmit symbol clock
// - continuously send one quinary symbol per pair
// - all four pairs update on one clock
// - leader role uses the local clock source
// - follower role uses the recovered clock
// - role value passed on continuously every cycle
`timescale 1ns/100ps
`default_nettype none
module rts_tx_clock_ctrl
  import rts_pkg::*;
#(
  parameter int LOCAL_DIV = LOCAL_DIV_DEF
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // reset requests
  input  wire logic             mgmt_reset_req_in,
  input  wire logic             phy_ctrl_reset_req_in,
  // role and recovered clock
  input  wire logic             role_indication_in,
  input  wire logic             recovered_clock_in,
  // symbol stream in
  input  wire logic             sym_valid_in,
  input  wire logic [SYM_W-1:0] sym_a_in,
  input  wire logic [SYM_W-1:0] sym_b_in,
  input  wire logic [SYM_W-1:0] sym_c_in,
  input  wire logic [SYM_W-1:0] sym_d_in,
  output var  logic             sym_ready_out,
  // pair outputs
  output var  logic [SYM_W-1:0] pair_a_out,
  output var  logic [SYM_W-1:0] pair_b_out,
  output var  logic [SYM_W-1:0] pair_c_out,
  output var  logic [SYM_W-1:0] pair_d_out,
  output var  logic             symbol_tick_out,
  // status
  output var  logic             tx_clock_sel_out,
  output var  logic             role_indication_out,
  output var  logic             coding_reset_out,
  output var  logic             attach_reset_out
);

  // refused at elaboration: the divider counter is only eight bits wide
  if (LOCAL_DIV < 1 || LOCAL_DIV > 255) begin
    $error("rts_tx_clock_ctrl: LOCAL_DIV out of range");
  end

  localparam logic [7:0] DIV_LAST = 8'(LOCAL_DIV - 1);

  logic             rst_s1_q;
  logic             rst_n_q;
  logic             rc_s1_q;
  logic             rc_s2_q;
  logic             rc_s3_q;
  logic [CNT_W-1:0] coding_cnt_q;
  logic [CNT_W-1:0] attach_cnt_q;
  logic [7:0]       loc_cnt_q;
  logic             loc_tick;
  logic             rec_edge;
  logic             tick;
  logic             attach_req;
  logic             buf_valid;
  logic [PAIRS*SYM_W-1:0] buf_data;
  logic             buf_ready;

  // reset release through two flops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // recovered clock is asynchronous; only its synchronised copy is edge-detected
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
    end else begin
      rc_s1_q <= recovered_clock_in;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
    end
  end

  assign rec_edge = rc_s2_q && !rc_s3_q;

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      role_indication_out <= ROLE_LEADER;
    end else begin
      role_indication_out <= role_indication_in;
    end
  end

  // coding reset: power-on loads the counter, management reloads it
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      coding_cnt_q     <= RST_HOLD_CYC;
      coding_reset_out <= 1'b1;
    end else if (mgmt_reset_req_in) begin
      coding_cnt_q     <= RST_HOLD_CYC;
      coding_reset_out <= 1'b1;
    end else if (coding_cnt_q != 8'h00) begin
      coding_cnt_q     <= coding_cnt_q - 8'h01;
      coding_reset_out <= (coding_cnt_q > 8'h01);
    end
  end

  // a role change forces an attachment reset so the source swap happens quietly
  assign attach_req = mgmt_reset_req_in || phy_ctrl_reset_req_in ||
                      (role_indication_out != tx_clock_sel_out);

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      attach_cnt_q     <= RST_HOLD_CYC;
      attach_reset_out <= 1'b1;
    end else if (attach_req) begin
      attach_cnt_q     <= RST_HOLD_CYC;
      attach_reset_out <= 1'b1;
    end else if (attach_cnt_q != 8'h00) begin
      attach_cnt_q     <= attach_cnt_q - 8'h01;
      attach_reset_out <= (attach_cnt_q > 8'h01);
    end
  end

  // source follows the role only while ticks are held off
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_clock_sel_out <= SRC_LOCAL;
    end else if (attach_reset_out) begin
      tx_clock_sel_out <= (role_indication_out == ROLE_FOLLOWER) ?
                          SRC_RECOVERED : SRC_LOCAL;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      loc_cnt_q <= 8'h00;
    end else if (attach_reset_out || loc_cnt_q == 8'h00) begin
      loc_cnt_q <= DIV_LAST;
    end else begin
      loc_cnt_q <= loc_cnt_q - 8'h01;
    end
  end

  assign loc_tick = !attach_reset_out && (loc_cnt_q == 8'h00);
  assign tick     = !attach_reset_out &&
                    ((tx_clock_sel_out == SRC_RECOVERED) ? rec_edge : loc_tick);

  rts_pair_buf #(
    .W (PAIRS * SYM_W)
  ) u_buf (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_q),
    .wr_valid_in  (sym_valid_in),
    .wr_data_in   ({sym_a_in, sym_b_in, sym_c_in, sym_d_in}),
    .wr_ready_out (buf_ready),
    .rd_valid_out (buf_valid),
    .rd_data_out  (buf_data),
    .rd_ready_in  (tick)
  );

  assign sym_ready_out = buf_ready;

  // one enable drives all four pairs; an empty buffer sends idle, never a gap
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pair_a_out      <= IDLE_SYM;
      pair_b_out      <= IDLE_SYM;
      pair_c_out      <= IDLE_SYM;
      pair_d_out      <= IDLE_SYM;
      symbol_tick_out <= 1'b0;
    end else begin
      symbol_tick_out <= tick;
      if (tick) begin
        if (buf_valid) begin
          {pair_a_out, pair_b_out, pair_c_out, pair_d_out} <= buf_data;
        end else begin
          {pair_a_out, pair_b_out, pair_c_out, pair_d_out} <= {PAIRS{IDLE_SYM}};
        end
      end
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_q);

  coding_on_req_a: assert property (mgmt_reset_req_in |=> coding_reset_out [*2])
    else $error("coding reset not held after management request");
  attach_on_req_a: assert property (phy_ctrl_reset_req_in |=> attach_reset_out [*2])
    else $error("attachment reset not held after phy control request");
  tick_local_a: assert property (tx_clock_sel_out == SRC_LOCAL && loc_tick |=> symbol_tick_out)
    else $error("local divider tick not passed on");
  tick_quiet_a: assert property (attach_reset_out |=> !symbol_tick_out)
    else $error("symbol tick during attachment reset");
  pair_data_a: assert property (tick && buf_valid |=> pair_a_out == $past(buf_data[11:9]) &&
                                pair_d_out == $past(buf_data[2:0]))
    else $error("pair symbols do not match buffered vector");
  pairs_hold_a: assert property (!symbol_tick_out |-> $stable(pair_a_out) && $stable(pair_b_out)
                                 && $stable(pair_c_out) && $stable(pair_d_out))
    else $error("pair output changed without a symbol tick");
  leader_src_a: assert property ($fell(attach_reset_out) && role_indication_out == ROLE_LEADER
                                 |-> tx_clock_sel_out == SRC_LOCAL)
    else $error("leader not on local source");
  follower_src_a: assert property ($fell(attach_reset_out) && role_indication_out == ROLE_FOLLOWER
                                   |-> tx_clock_sel_out == SRC_RECOVERED)
    else $error("follower not on recovered source");
  role_pass_a: assert property (##1 role_indication_out == $past(role_indication_in))
    else $error("role indication not passed on");
  sel_in_reset_a: assert property ($changed(tx_clock_sel_out) |-> $past(attach_reset_out))
    else $error("clock source changed outside reset");

  cover_local_c: cover property (tx_clock_sel_out == SRC_LOCAL && symbol_tick_out);
  cover_recov_c: cover property (tx_clock_sel_out == SRC_RECOVERED && symbol_tick_out);
  cover_switch_c: cover property ($changed(tx_clock_sel_out));
  cover_stall_c: cover property (sym_valid_in && !sym_ready_out);

endmodule
`default_nettype wire

// [rts_pkg.sv]
// shared constants for the reset sequencer and transmit clock selector
// assumes one 100 MHz system clock feeds every user of this package
package rts_pkg;

  localparam int          CLK_PERIOD_NS    = 10;
  // reset pulse length, least time, so rounded up
  localparam int          RST_HOLD_NS      = 100;
  localparam int          RST_HOLD_CYC_I   = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W            = 8;
  localparam logic [7:0]  RST_HOLD_CYC     = RST_HOLD_CYC_I[7:0];
  // local symbol period, divided down from the system clock
  localparam int          LOCAL_SYM_NS     = 40;
  localparam int          LOCAL_DIV_DEF    = LOCAL_SYM_NS / CLK_PERIOD_NS;

  // quinary symbol coding on each pair
  localparam int          SYM_W            = 3;
  localparam int          PAIRS            = 4;
  localparam logic [2:0]  IDLE_SYM         = 3'h0;
  localparam int          BUF_DEPTH        = 2;

  typedef enum logic {
    SRC_LOCAL     = 1'b0,
    SRC_RECOVERED = 1'b1
  } rts_src_t;

  typedef enum logic {
    ROLE_LEADER   = 1'b0,
    ROLE_FOLLOWER = 1'b1
  } rts_role_t;

endpackage

// [rts_pair_buf.sv]
// two-entry buffer for the four-pair symbol vector
// assumes writer and reader share clk_in; ready on the write side is registered
`timescale 1ns/100ps
`default_nettype none
module rts_pair_buf
  import rts_pkg::*;
#(
  parameter int W = PAIRS * SYM_W
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // write side
  input  wire logic         wr_valid_in,
  input  wire logic [W-1:0] wr_data_in,
  output var  logic         wr_ready_out,
  // read side
  output var  logic         rd_valid_out,
  output var  logic [W-1:0] rd_data_out,
  input  wire logic         rd_ready_in
);

  // pointers and count are sized for exactly two entries
  if (W < 1 || BUF_DEPTH != 2) begin
    $error("rts_pair_buf: width must be positive and depth two");
  end

  logic [W-1:0] mem_q [BUF_DEPTH];
  logic         wr_ptr_q;
  logic         rd_ptr_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;
  logic [1:0]   cnt_d;

  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;
  assign rd_valid_out = (cnt_q != 2'h0);
  assign rd_data_out  = mem_q[rd_ptr_q];
  assign cnt_d        = cnt_q + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q        <= 2'h0;
      wr_ready_out <= 1'b0;
    end else begin
      cnt_q        <= cnt_d;
      wr_ready_out <= (cnt_d != 2'h2);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
    end else begin
      if (push) wr_ptr_q <= ~wr_ptr_q;
      if (pop) rd_ptr_q <= ~rd_ptr_q;
    end
  end

  // storage needs no reset; it is only read while the count says valid
  always_ff @(posedge clk_in) begin
    if (push) mem_q[wr_ptr_q] <= wr_data_in;
  end

endmodule
`default_nettype wire

// [rts_link_peer.sv]
// link partner model: drives the recovered clock pin
// assumes the bench raises run_in only while it wants the far side clocked
`timescale 1ns/100ps
`default_nettype none
module rts_link_peer (
  // control
  input  wire logic run_in,
  // toward the block
  output var  logic rclk_out,
  output var  int   edges_out
);
  // period unrelated to clk_in; stands still low outside frames
  initial begin
    rclk_out = 1'b0;
    edges_out = 0;
    forever begin
      #37;
      if (run_in) begin
        rclk_out = ~rclk_out;
        if (rclk_out) edges_out++;
      end else begin
        rclk_out = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [tb.sv]
// bench for the reset sequencer and transmit clock selector
// assumes a 100 MHz clock and the link peer model on the recovered clock pin
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rts_pkg::*;
  logic        clk, rst_n, mreq, preq, role, sv, run;
  logic [11:0] sym, prev;
  wire logic   rclk, rdy, tick, sel, ro, crst, arst;
  wire logic [2:0] pa, pb, pc, pd;
  int          pe, fails, n_compared, cyc, lt, gap, nt, stalls;
  logic [11:0] seen[$];

  rts_link_peer peer (.run_in(run), .rclk_out(rclk), .edges_out(pe));
  rts_tx_clock_ctrl #(.LOCAL_DIV(4)) DUT (.clk_in(clk), .rst_n_in(rst_n),
    .mgmt_reset_req_in(mreq), .phy_ctrl_reset_req_in(preq),
    .role_indication_in(role), .recovered_clock_in(rclk), .sym_valid_in(sv),
    .sym_a_in(sym[11:9]), .sym_b_in(sym[8:6]), .sym_c_in(sym[5:3]),
    .sym_d_in(sym[2:0]), .sym_ready_out(rdy), .pair_a_out(pa), .pair_b_out(pb),
    .pair_c_out(pc), .pair_d_out(pd), .symbol_tick_out(tick),
    .tx_clock_sel_out(sel), .role_indication_out(ro),
    .coding_reset_out(crst), .attach_reset_out(arst));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [11:0] e, s);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // a hang ends the run as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_of_test();
    end
  end

  // pairs may only move in a tick cycle, all four together
  always @(posedge clk) begin
    #1;
    if (rst_n && {pa, pb, pc, pd} !== prev) chk("tick_on_change", 12'h1, {11'h0, tick});
    prev = {pa, pb, pc, pd};
    if (rst_n && tick) begin
      gap = cyc - lt;
      lt = cyc;
      nt++;
      if (prev != 12'h0) seen.push_back(prev);
    end
  end

  task wait_lo();
    for (int i = 0; i < 40 && arst !== 1'b0; i++) @(posedge clk);
    #1;
  endtask

  task t_reset();
    #1;
    chk("rst_flags", 12'h003, {7'h0, sel, rdy, tick, crst, arst});
    chk("rst_pairs", 12'h0, {pa, pb, pc, pd});
    @(posedge clk);
    rst_n <= 1'b1;
    wait_lo();
    chk("coding_free", 12'h0, {11'h0, crst});
    $display("done reset");
  endtask

  task automatic req(input logic m);
    int nc = 0;
    int na = 0;
    @(posedge clk);
    if (m) mreq <= 1'b1;
    else preq <= 1'b1;
    @(posedge clk);
    mreq <= 1'b0;
    preq <= 1'b0;
    repeat (30) begin
      #1;
      // an unknown level counts heavily so it can never pass as low
      nc += (crst === 1'b1) ? 1 : ((crst === 1'b0) ? 0 : 100);
      na += (arst === 1'b1) ? 1 : ((arst === 1'b0) ? 0 : 100);
      @(posedge clk);
    end
    chk("coding_len", m ? 12'h00a : 12'h000, 12'(nc));
    chk("attach_len", 12'h00a, 12'(na));
    $display("done request %0d", m);
  endtask

  function automatic logic [11:0] vec(int k);
    return {3'(k % 5), 3'((k + 1) % 5), 3'((k + 2) % 5), 3'((k + 3) % 5)};
  endfunction

  task automatic send(input logic [11:0] v);
    sym <= v;
    sv <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 40 && rdy !== 1'b1; i++) begin
      stalls++;
      @(posedge clk);
    end
  endtask

  task automatic t_stream();
    seen.delete();
    stalls = 0;
    @(posedge clk);
    for (int k = 1; k <= 6; k++) send(vec(k));
    sv <= 1'b0;
    repeat (40) @(posedge clk);
    #1;
    chk("refused", 12'h1, {11'h0, stalls > 0});
    chk("count", 12'h006, 12'(seen.size()));
    for (int k = 1; k <= 6 && k <= seen.size(); k++) chk("vector", vec(k), seen[k-1]);
    chk("local_gap", 12'h004, 12'(gap));
    $display("done stream");
  endtask

  task automatic t_follow();
    int n0;
    int p0;
    @(posedge clk);
    role <= 1'b1;
    @(posedge clk);
    #1;
    chk("role_out", 12'h1, {11'h0, ro});
    for (int i = 0; i < 10 && sel !== 1'b1; i++) @(posedge clk);
    #1;
    chk("sel_recov", 12'h1, {11'h0, sel});
    chk("switch_in_rst", 12'h1, {11'h0, arst});
    wait_lo();
    n0 = nt;
    repeat (30) @(posedge clk);
    #1;
    chk("no_local_tick", 12'h0, 12'(nt - n0));
    n0 = nt;
    p0 = pe;
    run <= 1'b1;
    repeat (300) @(posedge clk);
    run <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk("tick_per_edge", 12'h1, {11'h0, (nt - n0) - (pe - p0) inside {[-1:1]}});
    @(posedge clk);
    role <= 1'b0;
    repeat (3) @(posedge clk);
    wait_lo();
    chk("sel_local", 12'h0, {11'h0, sel});
    repeat (20) @(posedge clk);
    #1;
    chk("gap_back", 12'h004, 12'(gap));
    $display("done follow");
  endtask

  initial begin
    rst_n = 1'b0;
    mreq = 1'b0;
    preq = 1'b0;
    role = 1'b0;
    sv = 1'b0;
    sym = 12'h0;
    run = 1'b0;
    repeat (20) @(posedge clk);
    t_reset();
    req(1'b1);
    req(1'b0);
    t_stream();
    t_follow();
    // second reset in mid-run, taken asynchronously
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
